/* design/spmc_pkg.sv */
// Shared constants, register map and carrier types of the standby sequencer.
package spmc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   localparam int MCLK_PERIOD_NS = 50;
   localparam int OSC_STABLE_MS = 8;
   localparam int OSC_STABLE_CYC = OSC_STABLE_MS * 1000000 / MCLK_PERIOD_NS;
   localparam int STAB_BASE_STATES = 8192;
   localparam int STAB_SHORT_STATES = 16;
   localparam int STAB_CNT_W = 19;
   localparam logic [2:0] STS_RESERVED = 3'h6;
   localparam logic [2:0] STS_SHORT = 3'h7;
   localparam logic [2:0] STS_LONGEST = 3'h5;

   ////////////////////////////////////////////////////////////////////////////
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_SYS_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SBY_CTRL = 8'h04;
   localparam logic [7:0] ADDR_CLK_CTRL = 8'h08;
   localparam logic [7:0] ADDR_CLK_DIR = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;

   localparam int SYS_MEM_EN_BIT = 0;
   localparam int SYS_NMI_EDGE_BIT = 3;
   localparam int SBY_STS_LSB = 0;
   localparam int SBY_HOLD_BIT = 6;
   localparam int SBY_SELECT_BIT = 7;
   localparam int CLK_HALT_BIT = 7;
   localparam int DIR_CLK_BIT = 0;
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_BOOT_LSB = 4;

   localparam logic MEM_EN_RST = 1'h1;
   localparam logic NMI_EDGE_RST = 1'h0;
   localparam logic SBY_SELECT_RST = 1'h0;
   localparam logic BUS_HOLD_RST = 1'h0;
   localparam logic [2:0] STS_RST = 3'h0;
   localparam logic CLK_HALT_RST = 1'h0;
   localparam logic CLK_DIR_RST = 1'h1;

   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {
      MODE_RESET = 3'b000,
      MODE_RUN = 3'b001,
      MODE_SLEEP = 3'b010,
      MODE_SW_STANDBY = 3'b011,
      MODE_OSC_WAIT = 3'b100,
      MODE_HW_STANDBY = 3'b101
   } spmc_mode_t;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
   } spmc_ahb_req_t;

   typedef struct packed {
      logic nmi_edge_select;
      logic onchip_memory_enable;
      logic standby_select;
      logic bus_output_hold;
      logic [2:0] stab_select;
      logic clock_pin_halt;
      logic clock_pin_dir;
   } spmc_cfg_t;

   localparam spmc_cfg_t CFG_RST = '{NMI_EDGE_RST, MEM_EN_RST,
      SBY_SELECT_RST, BUS_HOLD_RST, STS_RST, CLK_HALT_RST, CLK_DIR_RST};

   typedef struct packed {
      logic cpu_reset;
      logic cpu_clk_en;
      logic periph_clk_en;
      logic osc_en;
      logic mem_hold;
   } spmc_core_ctl_t;

   localparam spmc_core_ctl_t CORE_CTL_RST = 5'h13;

endpackage

/* design/spmc_sync.sv */
// Two-flop synchroniser for a group of asynchronous pin levels.
`timescale 1ns/100ps
`default_nettype none
module spmc_sync #(
   parameter int W = 2,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] stage1;

   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            stage1[i] <= RST_VAL[i];
            dout[i] <= RST_VAL[i];
         end else begin
            stage1[i] <= din[i];
            dout[i] <= stage1[i];
         end
      end
   end
endmodule
`default_nettype wire

/* design/spmc_stab_timer.sv */
// Oscillation stabilisation wait counter with selectable length.
`timescale 1ns/100ps
`default_nettype none
module spmc_stab_timer
   import spmc_pkg::*;
#(
   parameter int BASE = STAB_BASE_STATES,
   parameter int SHORT = STAB_SHORT_STATES,
   parameter int W = STAB_CNT_W
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic start,
   input wire logic [2:0] sel,
   output logic done
);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic next_done;
   logic [W-1:0] load;

   always_comb begin
      if (sel == STS_SHORT) begin
         load = W'(SHORT);
      end else if (sel == STS_RESERVED) begin
         load = W'(BASE << STS_LONGEST);
      end else begin
         load = W'(BASE << sel);
      end
      next_cnt = cnt;
      next_done = 1'b0;
      if (start) begin
         next_cnt = load;
      end else if (cnt != '0) begin
         next_cnt = cnt - W'(1);
         next_done = (cnt == W'(1));
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt <= '0;
         done <= 1'b0;
      end else begin
         cnt <= next_cnt;
         done <= next_done;
      end
   end
endmodule
`default_nettype wire

/* design/spmc_top.sv */
// Standby and power-mode sequencer with its AHB-Lite register slave.
`timescale 1ns/100ps
`default_nettype none
module spmc_top #(
   parameter int GPIO_W = 16,
   parameter int BUS_W = 24,
   parameter int STAB_BASE = spmc_pkg::STAB_BASE_STATES,
   parameter int STAB_SHORT = spmc_pkg::STAB_SHORT_STATES
) (
   input wire logic mclk,
   input wire logic rst,
   input wire spmc_pkg::spmc_ahb_req_t ahb_req,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic sleep_exec,
   input wire logic bus_cycle_end,
   input wire logic nmi_pin,
   input wire logic irq_wake,
   input wire logic hw_standby_pin_n,
   input wire logic chip_clear_pin_n,
   input wire logic [2:0] boot_select_pins,
   input wire logic [GPIO_W-1:0] gpio_out_live,
   input wire logic [GPIO_W-1:0] gpio_oe_live,
   input wire logic [BUS_W-1:0] bus_out_live,
   output logic [GPIO_W-1:0] gpio_pin_out,
   output logic [GPIO_W-1:0] gpio_pin_oe,
   output logic [BUS_W-1:0] bus_pin_out,
   output logic bus_pin_oe,
   output logic sysclk_pin_out,
   output logic sysclk_pin_oe,
   output spmc_pkg::spmc_core_ctl_t core_ctl,
   output logic nmi_request,
   output logic reset_exception,
   output logic wake_exception,
   output logic onchip_memory_enable
);
   import spmc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and NMI edge detection.
   logic [1:0] pins_sync;
   logic hw_standby_pin_n_s;
   logic clr_n_s;
   logic nmi_prev;
   logic nmi_event;

   spmc_sync #(
      .W(2),
      .RST_VAL(2'h3)
   ) u_pin_sync (
      .mclk(mclk),
      .rst(rst),
      .din({hw_standby_pin_n, chip_clear_pin_n}),
      .dout(pins_sync)
   );

   assign hw_standby_pin_n_s = pins_sync[1];
   assign clr_n_s = pins_sync[0];

   spmc_cfg_t cfg;
   spmc_cfg_t next_cfg;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         nmi_prev <= 1'b0;
      end else begin
         nmi_prev <= nmi_pin;
      end
   end

   always_comb begin
      if (cfg.nmi_edge_select) begin
         nmi_event = nmi_pin & ~nmi_prev;
      end else begin
         nmi_event = ~nmi_pin & nmi_prev;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode state machine.
   spmc_mode_t mode;
   spmc_mode_t next_mode;
   spmc_core_ctl_t next_core_ctl;
   logic next_nmi_request;
   logic next_reset_exception;
   logic next_wake_exception;
   logic timer_start;
   logic timer_done;
   logic func_clear;
   logic in_sw_standby;

   assign func_clear = (mode == MODE_RESET) || (mode == MODE_HW_STANDBY);
   assign in_sw_standby = (mode == MODE_SW_STANDBY) || (mode == MODE_OSC_WAIT);

   spmc_stab_timer #(
      .BASE(STAB_BASE),
      .SHORT(STAB_SHORT),
      .W(STAB_CNT_W)
   ) u_stab_timer (
      .mclk(mclk),
      .rst(rst),
      .start(timer_start),
      .sel(cfg.stab_select),
      .done(timer_done)
   );

   always_comb begin
      next_mode = mode;
      next_nmi_request = 1'b0;
      next_reset_exception = 1'b0;
      next_wake_exception = 1'b0;
      timer_start = 1'b0;
      if (!hw_standby_pin_n_s) begin
         next_mode = MODE_HW_STANDBY;
      end else if (mode == MODE_HW_STANDBY) begin
         next_mode = MODE_RESET;
      end else if (!clr_n_s) begin
         next_mode = MODE_RESET;
      end else begin
         case (mode)
            MODE_RESET: begin
               next_mode = MODE_RUN;
               next_reset_exception = 1'b1;
            end
            MODE_RUN: begin
               next_nmi_request = nmi_event;
               if (sleep_exec) begin
                  if (cfg.standby_select) begin
                     next_mode = MODE_SW_STANDBY;
                  end else begin
                     next_mode = MODE_SLEEP;
                  end
               end
            end
            MODE_SLEEP: begin
               next_nmi_request = nmi_event;
               if (nmi_event || irq_wake) begin
                  next_mode = MODE_RUN;
               end
            end
            MODE_SW_STANDBY: begin
               if (nmi_event || irq_wake) begin
                  next_mode = MODE_OSC_WAIT;
                  timer_start = 1'b1;
               end
            end
            MODE_OSC_WAIT: begin
               if (timer_done) begin
                  next_mode = MODE_RUN;
                  next_wake_exception = 1'b1;
               end
            end
            default: begin
               next_mode = MODE_RESET;
            end
         endcase
      end
      next_core_ctl.cpu_reset = (next_mode == MODE_RESET) ||
         (next_mode == MODE_HW_STANDBY);
      next_core_ctl.cpu_clk_en = (next_mode == MODE_RUN);
      next_core_ctl.periph_clk_en = (next_mode == MODE_RUN) ||
         (next_mode == MODE_SLEEP);
      next_core_ctl.osc_en = (next_mode != MODE_SW_STANDBY) &&
         (next_mode != MODE_HW_STANDBY);
      next_core_ctl.mem_hold = (next_mode == MODE_HW_STANDBY);
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mode <= MODE_RESET;
         core_ctl <= CORE_CTL_RST;
         nmi_request <= 1'b0;
         reset_exception <= 1'b0;
         wake_exception <= 1'b0;
      end else begin
         mode <= next_mode;
         core_ctl <= next_core_ctl;
         nmi_request <= next_nmi_request;
         reset_exception <= next_reset_exception;
         wake_exception <= next_wake_exception;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave and control registers.
   logic dp_write;
   logic [ADDR_W-1:0] dp_addr;
   logic next_dp_write;
   logic [ADDR_W-1:0] next_dp_addr;
   logic [31:0] next_hrdata;
   logic [2:0] boot_latched;
   logic [2:0] next_boot_latched;
   logic [31:0] rd_word;
   logic accept;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign onchip_memory_enable = cfg.onchip_memory_enable;
   assign accept = ahb_req.hsel && ahb_req.htrans[1] && hready;

   always_comb begin
      rd_word = 32'h0;
      case (ahb_req.haddr[ADDR_W-1:0])
         ADDR_SYS_CTRL: begin
            rd_word[SYS_MEM_EN_BIT] = cfg.onchip_memory_enable;
            rd_word[SYS_NMI_EDGE_BIT] = cfg.nmi_edge_select;
         end
         ADDR_SBY_CTRL: begin
            rd_word[SBY_STS_LSB +: 3] = cfg.stab_select;
            rd_word[SBY_HOLD_BIT] = cfg.bus_output_hold;
            rd_word[SBY_SELECT_BIT] = cfg.standby_select;
         end
         ADDR_CLK_CTRL: begin
            rd_word[CLK_HALT_BIT] = cfg.clock_pin_halt;
         end
         ADDR_CLK_DIR: begin
            rd_word[DIR_CLK_BIT] = cfg.clock_pin_dir;
         end
         ADDR_STATUS: begin
            rd_word[STAT_MODE_LSB +: 3] = mode;
            rd_word[STAT_BOOT_LSB +: 3] = boot_latched;
         end
         default: begin
            rd_word = 32'h0;
         end
      endcase
   end

   always_comb begin
      next_dp_write = accept && ahb_req.hwrite;
      next_dp_addr = accept ? ahb_req.haddr[ADDR_W-1:0] : dp_addr;
      next_hrdata = (accept && !ahb_req.hwrite) ? rd_word : hrdata;
      next_boot_latched = (mode == MODE_RESET) ? boot_select_pins :
         boot_latched;
      next_cfg = cfg;
      if (func_clear) begin
         next_cfg = CFG_RST;
      end else if (dp_write) begin
         case (dp_addr)
            ADDR_SYS_CTRL: begin
               next_cfg.onchip_memory_enable = hwdata[SYS_MEM_EN_BIT];
               next_cfg.nmi_edge_select = hwdata[SYS_NMI_EDGE_BIT];
            end
            ADDR_SBY_CTRL: begin
               next_cfg.stab_select = hwdata[SBY_STS_LSB +: 3];
               next_cfg.bus_output_hold = hwdata[SBY_HOLD_BIT];
               next_cfg.standby_select = hwdata[SBY_SELECT_BIT];
            end
            ADDR_CLK_CTRL: begin
               next_cfg.clock_pin_halt = hwdata[CLK_HALT_BIT];
            end
            ADDR_CLK_DIR: begin
               next_cfg.clock_pin_dir = hwdata[DIR_CLK_BIT];
            end
            default: begin
               next_cfg = cfg;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dp_write <= 1'b0;
         dp_addr <= '0;
         hrdata <= 32'h0;
         boot_latched <= 3'h0;
         cfg <= CFG_RST;
      end else begin
         dp_write <= next_dp_write;
         dp_addr <= next_dp_addr;
         hrdata <= next_hrdata;
         boot_latched <= next_boot_latched;
         cfg <= next_cfg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port, bus and clock pin drivers.
   logic [GPIO_W-1:0] next_gpio_pin_out;
   logic [GPIO_W-1:0] next_gpio_pin_oe;
   logic [BUS_W-1:0] next_bus_pin_out;
   logic next_bus_pin_oe;
   logic sysclk_halted;
   logic next_sysclk_halted;
   logic sysclk_high;
   logic next_sysclk_high;
   logic next_sysclk_pin_oe;

   always_comb begin
      next_gpio_pin_out = gpio_out_live;
      next_gpio_pin_oe = gpio_oe_live;
      next_bus_pin_out = bus_out_live;
      next_bus_pin_oe = 1'b1;
      if (cfg.clock_pin_halt) begin
         next_sysclk_halted = sysclk_halted | bus_cycle_end;
      end else begin
         next_sysclk_halted = 1'b0;
      end
      next_sysclk_high = next_sysclk_halted;
      next_sysclk_pin_oe = cfg.clock_pin_dir;
      if (mode == MODE_HW_STANDBY) begin
         next_gpio_pin_oe = '0;
         next_bus_pin_oe = 1'b0;
         next_sysclk_pin_oe = 1'b0;
      end else if (in_sw_standby) begin
         next_gpio_pin_out = gpio_pin_out;
         next_gpio_pin_oe = gpio_pin_oe;
         next_bus_pin_out = bus_pin_out;
         next_bus_pin_oe = cfg.bus_output_hold & bus_pin_oe;
         next_sysclk_high = 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gpio_pin_out <= '0;
         gpio_pin_oe <= '0;
         bus_pin_out <= '0;
         bus_pin_oe <= 1'b0;
         sysclk_halted <= 1'b0;
         sysclk_high <= 1'b0;
         sysclk_pin_oe <= 1'b0;
      end else begin
         gpio_pin_out <= next_gpio_pin_out;
         gpio_pin_oe <= next_gpio_pin_oe;
         bus_pin_out <= next_bus_pin_out;
         bus_pin_oe <= next_bus_pin_oe;
         sysclk_halted <= next_sysclk_halted;
         sysclk_high <= next_sysclk_high;
         sysclk_pin_oe <= next_sysclk_pin_oe;
      end
   end

   // The pin shows the system clock until sysclk_high forces it high, on a clock halt or in software standby.
   assign sysclk_pin_out = mclk | sysclk_high;
endmodule
`default_nettype wire

/* verif/spmc_top_asserts.sv */
// Port checker of the standby sequencer.
`timescale 1ns/100ps
`default_nettype none
module spmc_top_asserts #(
   parameter int GPIO_W = 16,
   parameter int BUS_W = 24
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic nmi_pin,
   input wire logic hw_standby_pin_n,
   input wire logic chip_clear_pin_n,
   input wire logic [GPIO_W-1:0] gpio_pin_out,
   input wire logic [GPIO_W-1:0] gpio_pin_oe,
   input wire logic [BUS_W-1:0] bus_pin_out,
   input wire logic bus_pin_oe,
   input wire logic sysclk_pin_oe,
   input wire spmc_pkg::spmc_core_ctl_t core_ctl,
   input wire logic nmi_request,
   input wire logic reset_exception,
   input wire logic wake_exception
);
   import spmc_pkg::*;
   logic sw_sby;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   assign sw_sby = !core_ctl.osc_en && !core_ctl.cpu_reset;
   ////////////////////////////////////////
   a_hw_float: assert property (
      !hw_standby_pin_n [*6] |-> !(|gpio_pin_oe) && !bus_pin_oe
      && !sysclk_pin_oe) else $error("pads driven in standby");
   a_hw_reset: assert property (
      !hw_standby_pin_n [*6] |-> core_ctl.cpu_reset && !core_ctl.cpu_clk_en)
      else $error("core runs in standby");
   a_mem_kept: assert property (
      !hw_standby_pin_n [*6] |-> core_ctl.mem_hold)
      else $error("memory not held");
   a_reset_cause: assert property (
      reset_exception |-> $past(chip_clear_pin_n, 2)
      && $past(hw_standby_pin_n, 2)) else $error("reset exception early");
   a_reset_pulse: assert property (
      reset_exception |=> !reset_exception) else $error("reset pulse long");
   a_wake_osc: assert property (
      wake_exception |-> core_ctl.osc_en && $past(core_ctl.osc_en, 2)
      ##1 !wake_exception) else $error("wake before oscillator");
   a_port_hold: assert property (
      sw_sby && $past(sw_sby) |-> $stable(gpio_pin_out)
      && $stable(gpio_pin_oe)) else $error("port moved in standby");
   a_bus_hold: assert property (
      sw_sby && $past(sw_sby) && bus_pin_oe |-> $stable(bus_pin_out))
      else $error("bus moved in standby");
   a_nmi_edge: assert property (
      nmi_request |-> $past(nmi_pin) != $past(nmi_pin, 2)
      || $past(nmi_pin, 2) != $past(nmi_pin, 3)) else $error("nmi no edge");
   c_reset: cover property (reset_exception);
   c_wake: cover property (wake_exception);
   c_nmi: cover property (nmi_request);
endmodule
bind spmc_top spmc_top_asserts #(.GPIO_W(GPIO_W), .BUS_W(BUS_W)) u_chk (
   .mclk(mclk), .rst(rst), .nmi_pin(nmi_pin),
   .hw_standby_pin_n(hw_standby_pin_n), .chip_clear_pin_n(chip_clear_pin_n),
   .gpio_pin_out(gpio_pin_out), .gpio_pin_oe(gpio_pin_oe),
   .bus_pin_out(bus_pin_out), .bus_pin_oe(bus_pin_oe),
   .sysclk_pin_oe(sysclk_pin_oe), .core_ctl(core_ctl),
   .nmi_request(nmi_request), .reset_exception(reset_exception),
   .wake_exception(wake_exception));
`default_nettype wire

/* verif/spmc_board_model.sv */
// Board logic model that sequences the standby and clear pins.
`timescale 1ns/100ps
`default_nettype none
module spmc_board_model #(
   parameter int HOLD = 20,
   parameter logic [2:0] BOOT = 3'h5
) (
   input wire logic mclk,
   output logic hw_standby_pin_n,
   output logic chip_clear_pin_n,
   output logic [2:0] boot_select_pins
);
   int cyc;
   int t_rel;
   initial begin
      hw_standby_pin_n = 1'b1;
      chip_clear_pin_n = 1'b1;
      cyc = 0;
      t_rel = 0;
   end
   assign boot_select_pins = BOOT;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
   end
   task automatic enter_standby();
      chip_clear_pin_n <= 1'b0;
      repeat (2) @(posedge mclk);
      hw_standby_pin_n <= 1'b0;
   endtask
   task automatic release_standby();
      hw_standby_pin_n <= 1'b1;
      t_rel = cyc;
   endtask
   task automatic release_clear();
      while (cyc - t_rel < HOLD) @(posedge mclk);
      chip_clear_pin_n <= 1'b1;
   endtask
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking testbench of the standby sequencer.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import spmc_pkg::*;
   localparam logic [2:0] BOOT = 3'h5;
   logic mclk, rst, hready, hresp, hreadyout, sleep_exec, bus_cycle_end;
   logic nmi_pin, irq_wake, bus_pin_oe, sysclk_pin_out, sysclk_pin_oe;
   logic nmi_request, reset_exception, wake_exception, onchip_memory_enable;
   logic hw_standby_pin_n, chip_clear_pin_n;
   logic [2:0] boot_select_pins;
   logic [31:0] hwdata, hrdata, rd;
   logic [15:0] gpio_out_live, gpio_oe_live, gpio_pin_out, gpio_pin_oe;
   logic [23:0] bus_out_live, bus_pin_out;
   spmc_ahb_req_t ahb_req;
   spmc_core_ctl_t core_ctl;
   int err_count, check_count, n;
   assign hready = hreadyout;
   spmc_top #(.STAB_BASE(8), .STAB_SHORT(2)) dut (.mclk(mclk), .rst(rst),
      .ahb_req(ahb_req), .hready(hready), .hwdata(hwdata),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .sleep_exec(sleep_exec), .bus_cycle_end(bus_cycle_end),
      .nmi_pin(nmi_pin), .irq_wake(irq_wake),
      .hw_standby_pin_n(hw_standby_pin_n),
      .chip_clear_pin_n(chip_clear_pin_n),
      .boot_select_pins(boot_select_pins),
      .gpio_out_live(gpio_out_live), .gpio_oe_live(gpio_oe_live),
      .bus_out_live(bus_out_live), .gpio_pin_out(gpio_pin_out),
      .gpio_pin_oe(gpio_pin_oe), .bus_pin_out(bus_pin_out),
      .bus_pin_oe(bus_pin_oe), .sysclk_pin_out(sysclk_pin_out),
      .sysclk_pin_oe(sysclk_pin_oe), .core_ctl(core_ctl),
      .nmi_request(nmi_request), .reset_exception(reset_exception),
      .wake_exception(wake_exception),
      .onchip_memory_enable(onchip_memory_enable));
   spmc_board_model #(.HOLD(20), .BOOT(BOOT)) u_board (.mclk(mclk),
      .hw_standby_pin_n(hw_standby_pin_n),
      .chip_clear_pin_n(chip_clear_pin_n),
      .boot_select_pins(boot_select_pins));
   ////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude();
      if (err_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic xfer(input logic [7:0] a, input logic w,
      input logic [31:0] wd);
      ahb_req <= '{1'b1, {24'h0, a}, 2'h2, w, 3'h2};
      do @(posedge mclk); while (hready !== 1'b1);
      ahb_req.htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge mclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rcheck(input string nm, input logic [7:0] a,
      input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      check(nm, rd, exp);
   endtask
   function automatic logic [31:0] st(input logic [2:0] m);
      return {25'h0, BOOT, 1'b0, m};
   endfunction
   task automatic wait_pulse(input bit wk);
      n = 0;
      while ((wk ? wake_exception : reset_exception) !== 1'b1 && n < 300)
      begin
         @(posedge mclk);
         n++;
      end
   endtask
   task automatic pulse_sleep();
      sleep_exec <= 1'b1;
      @(posedge mclk);
      sleep_exec <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask
   task automatic t_boot();
      xfer(8'h14, 1'b1, 32'hFF);
      rcheck("status", ADDR_STATUS, st(MODE_RUN));
      rcheck("sys ctrl", ADDR_SYS_CTRL, 32'h1);
   endtask
   task automatic t_nmi();
      for (int s = 0; s < 2; s++) begin
         xfer(ADDR_SYS_CTRL, 1'b1, 32'h1 | (s << SYS_NMI_EDGE_BIT));
         for (int lv = 1; lv >= 0; lv--) begin
            nmi_pin <= lv[0];
            n = 0;
            repeat (4) begin
               @(posedge mclk);
               if (nmi_request === 1'b1) n++;
            end
            check("nmi request", n, (lv == s) ? 1 : 0);
         end
      end
   endtask
   task automatic t_sleep();
      xfer(ADDR_SBY_CTRL, 1'b1, 32'h0);
      pulse_sleep();
      rcheck("sleep mode", ADDR_STATUS, st(MODE_SLEEP));
      irq_wake <= 1'b1;
      repeat (2) @(posedge mclk);
      irq_wake <= 1'b0;
      rcheck("sleep woke", ADDR_STATUS, st(MODE_RUN));
   endtask
   task automatic clk_chk(input logic v, input logic oe);
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      if (oe) check("clk pin", sysclk_pin_out, v);
      check("clk oe", sysclk_pin_oe, oe);
      @(posedge mclk);
   endtask
   task automatic t_clk();
      clk_chk(1'b0, 1'b1);
      xfer(ADDR_CLK_CTRL, 1'b1, 32'h80);
      clk_chk(1'b0, 1'b1);
      bus_cycle_end <= 1'b1;
      @(posedge mclk);
      bus_cycle_end <= 1'b0;
      clk_chk(1'b1, 1'b1);
      xfer(ADDR_CLK_DIR, 1'b1, 32'h0);
      clk_chk(1'b1, 1'b0);
      xfer(ADDR_CLK_CTRL, 1'b1, 32'h0);
      xfer(ADDR_CLK_DIR, 1'b1, 32'h1);
   endtask
   task automatic t_sw(input logic [7:0] cfg, input int n_min);
      gpio_out_live <= 16'hA5C3;
      bus_out_live <= 24'h3C5A96;
      xfer(ADDR_SBY_CTRL, 1'b1, {24'h0, cfg});
      pulse_sleep();
      gpio_out_live <= 16'h0F0F;
      bus_out_live <= 24'h0;
      repeat (3) @(posedge mclk);
      check("gpio hold", gpio_pin_out, 32'hA5C3);
      check("bus oe", bus_pin_oe, cfg[6]);
      if (cfg[6]) check("bus hold", bus_pin_out, 32'h3C5A96);
      check("osc off", core_ctl.osc_en, 1'b0);
      clk_chk(1'b1, 1'b1);
      if (cfg[6]) irq_wake <= 1'b1;
      else nmi_pin <= 1'b1;
      wait_pulse(1'b1);
      irq_wake <= 1'b0;
      nmi_pin <= 1'b0;
      check("wake seen", wake_exception, 1'b1);
      check("wake wait", n, n_min + 3);
      repeat (2) @(posedge mclk);
      check("gpio live", gpio_pin_out, 32'h0F0F);
   endtask
   task automatic t_hw();
      xfer(ADDR_SYS_CTRL, 1'b1, 32'h8);
      @(posedge mclk);
      check("mem enable", onchip_memory_enable, 1'b0);
      xfer(ADDR_CLK_CTRL, 1'b1, 32'h80);
      pulse_sleep();
      u_board.enter_standby();
      repeat (6) @(posedge mclk);
      check("gpio oe", gpio_pin_oe, 32'h0);
      check("mem hold", core_ctl.mem_hold, 1'b1);
      check("cpu reset", core_ctl.cpu_reset, 1'b1);
      rcheck("hw mode", ADDR_STATUS, st(MODE_HW_STANDBY));
      u_board.release_standby();
      repeat (4) @(posedge mclk);
      rcheck("reset mode", ADDR_STATUS, st(MODE_RESET));
      check("osc on", core_ctl.osc_en, 1'b1);
      rcheck("halt cleared", ADDR_CLK_CTRL, 32'h0);
      u_board.release_clear();
      wait_pulse(1'b0);
      check("reset exc", reset_exception, 1'b1);
      repeat (2) @(posedge mclk);
      rcheck("run mode", ADDR_STATUS, st(MODE_RUN));
   endtask
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial begin
      rst = 1'b1;
      ahb_req = '0;
      hwdata = '0;
      sleep_exec = 1'b0;
      bus_cycle_end = 1'b0;
      nmi_pin = 1'b0;
      irq_wake = 1'b0;
      gpio_out_live = '0;
      gpio_oe_live = 16'hFFFF;
      bus_out_live = '0;
      err_count = 0;
      check_count = 0;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      wait_pulse(1'b0);
      check("boot exc", reset_exception, 1'b1);
      t_boot();
      t_nmi();
      t_sleep();
      t_clk();
      t_sw(8'hC7, 2);
      t_sw(8'h81, 16);
      t_hw();
      conclude();
   end
   initial begin
      repeat (5000) @(posedge mclk);
      err_count++;
      conclude();
   end
endmodule
`default_nettype wire
